// *** core/fps_pkg.sv ***
// package for the flyback protection supervisor
package fps_pkg;
    localparam int CLK_HZ = 125_000_000;
    // timing in their own units
    localparam int OPP_NORMAL_MS = 200;
    localparam int OPP_START_MS = 40;
    localparam int PROT_FILT_MIN_MS = 2;
    localparam int PROT_FILT_MAX_MS = 4;
    localparam int TICK_MS = 1;
    localparam int MAX_ON_US = 55;
    localparam int RESTART_MS = 100;
    // derived cycle counts
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int MAX_ON_CYC = CLK_HZ / 1_000_000 * MAX_ON_US;
    // comparisons counted in 1 ms ticks
    localparam int OPP_NORMAL_TICKS = OPP_NORMAL_MS / TICK_MS;
    localparam int OPP_START_TICKS = OPP_START_MS / TICK_MS;
    localparam int PROT_FILT_TICKS = (PROT_FILT_MIN_MS + PROT_FILT_MAX_MS) / (2 * TICK_MS);
    localparam int RESTART_TICKS = RESTART_MS / TICK_MS;
    localparam int OVP_PULSES = 4;
    // feedback levels in microamps
    localparam logic [7:0] FB_TARGET_UA = 8'h50;
    localparam logic [7:0] FB_FAST_DROP_UA = 8'h14;
    localparam logic [15:0] OFFSET_RESET = 16'h8000;
    localparam int SLOW_SHIFT = 6;

    typedef enum logic [2:0] {
        FPS_ST_WAIT,
        FPS_ST_RUN,
        FPS_ST_RESTART,
        FPS_ST_SOURCES,
        FPS_ST_SOFTSTART,
        FPS_ST_LATCHED
    } fps_state_t;

    // comparator flags from the analog side
    typedef struct packed {
        logic overpower;
        logic supply_undervoltage_lockout;
        logic aux_ovp;
        logic low_supply_ovp;
        logic fault_low;
        logic junction_hot;
        logic mains_ok;
        logic in_regulation;
        logic pins_ready;
        logic secondary_stroke;
    } fps_flags_t;

    // supply and restart controls
    typedef struct packed {
        logic supply_regulate;
        logic supply_discharge;
        logic fault_source_en;
        logic feedback_source_en;
        logic softstart_en;
    } fps_supply_t;
endpackage

// *** core/fps_sync.sv ***
// two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module fps_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_bad_width
        $error("fps_sync width must be positive");
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** core/fps_supervisor.sv ***
// protection supervisor of a flyback controller
// Notes on behaviour
// - overpower ends gate pulse, starts timer
// - continuous overpower 200 ms gives restart
// - start-up uses 40 ms overpower limit
// - overpower with undervoltage trips immediately
// - aux overvoltage sampled in secondary stroke
// - supply overvoltage sampled at primary end
// - overvoltage trips after four consecutive pulses
// - fault input low stops, means overtemperature
// - fault input filtered 2 to 4 ms
// - junction overtemperature stops switching
// - 55 us on-time cut, then restart
// - restart holds off, discharges, waits delay
// - after delay, mains ok enables sources
// - sources ready starts soft-start and switching
// - supply regulated until output in regulation
// - latched: supply regulated, no switching
// - latch or restart entry enables discharge
// - mains short adds no extra delay
// - integrate feedback error around 80 uA
// - 20 uA shortfall selects fast rate
// - fault low: overvoltage counter uses ticks
// - temperature, overvoltage latch; others restart
`timescale 1ns/1ps
module fps_supervisor
    import fps_pkg::*;
#(
    parameter int OPP_NORMAL_T = OPP_NORMAL_TICKS,
    parameter int OPP_START_T = OPP_START_TICKS,
    parameter int PROT_FILT_T = PROT_FILT_TICKS,
    parameter int RESTART_T = RESTART_TICKS,
    parameter int TICK_C = TICK_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // analog comparator flags, asynchronous
    input wire fps_flags_t flags_in,
    // gate request from the modulator, same clock
    input wire logic gate_request_in,
    // feedback current in microamps, same clock
    input wire logic [7:0] feedback_ua_in,
    // gate and supply controls
    output logic gate_drive_out,
    output fps_supply_t supply_out,
    output logic [15:0] power_offset_out,
    output logic fast_mode_out,
    output fps_state_t state_out,
    output logic latch_fault_out,
    output logic restart_fault_out
);
    // refuse limits that the counters cannot hold
    if (OPP_START_T < 1 || OPP_START_T > OPP_NORMAL_T
        || OPP_NORMAL_T > 65535) begin : g_bad_opp
        $error("fps_supervisor overpower limits out of range");
    end
    if (PROT_FILT_T < 1 || PROT_FILT_T > 255 || RESTART_T < 1
        || RESTART_T > 65535 || TICK_C < 2) begin : g_bad_timing
        $error("fps_supervisor timing parameters out of range");
    end

    fps_flags_t fl;
    fps_sync #(.WIDTH($bits(fps_flags_t))) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(flags_in),
        .sync_out(fl)
    );

    fps_state_t state;
    fps_state_t next_state;
    logic [31:0] tick_cnt;
    logic [15:0] opp_cnt;
    logic [7:0] prot_cnt;
    logic [15:0] restart_cnt;
    logic [15:0] on_cnt;
    logic [2:0] ovp_cnt;
    logic gate_q;
    logic ovp_seen;
    logic secondary_ovp_seen;
    logic started;
    logic [15:0] offset;
    logic prot_fault;

    // 1 ms tick shared by all slow timers
    wire tick = (tick_cnt == 32'(TICK_C - 1));
    wire switching = (state == FPS_ST_RUN) || (state == FPS_ST_SOFTSTART);
    wire [15:0] opp_limit = started ? 16'(OPP_NORMAL_T) : 16'(OPP_START_T);
    wire opp_timeout = fl.overpower && tick && (opp_cnt >= opp_limit - 16'h0001);
    wire opp_supply_undervoltage_lockout = fl.overpower && fl.supply_undervoltage_lockout;
    wire max_on = gate_q && (on_cnt >= 16'(MAX_ON_CYC - 1));
    // sample points for overvoltage
    // a pulse cut by overpower or on-time ends its primary stroke too
    wire primary_end = gate_q && (!gate_request_in || fl.overpower || max_on);
    wire ovp_now = secondary_ovp_seen || (primary_end && fl.low_supply_ovp);
    wire ovp_clock = fl.fault_low ? tick : primary_end;
    wire ovp_trip = ovp_clock && (ovp_seen || ovp_now) && (ovp_cnt == 3'(OVP_PULSES - 1));
    wire latch_req = switching && (ovp_trip || prot_fault || fl.junction_hot);
    wire restart_req = switching && (opp_timeout || opp_supply_undervoltage_lockout || max_on);
    wire next_gate = switching && gate_request_in && !fl.overpower && !max_on
        && !latch_req && !restart_req;

    always_comb begin
        next_state = state;
        case (state)
            FPS_ST_WAIT: begin
                if (fl.mains_ok)
                    next_state = FPS_ST_SOURCES;
            end
            FPS_ST_RUN, FPS_ST_SOFTSTART: begin
                if (latch_req)
                    next_state = FPS_ST_LATCHED;
                else if (restart_req)
                    next_state = FPS_ST_RESTART;
                else if (state == FPS_ST_SOFTSTART && fl.in_regulation)
                    next_state = FPS_ST_RUN;
            end
            FPS_ST_RESTART: begin
                // delay, cut short by mains loss
                if (!fl.mains_ok)
                    next_state = FPS_ST_WAIT;
                else if (tick && restart_cnt >= 16'(RESTART_T - 1))
                    next_state = FPS_ST_SOURCES;
            end
            FPS_ST_SOURCES: begin
                if (!fl.mains_ok)
                    next_state = FPS_ST_WAIT;
                else if (fl.pins_ready)
                    next_state = FPS_ST_SOFTSTART;
            end
            FPS_ST_LATCHED: begin
                if (!fl.mains_ok)
                    next_state = FPS_ST_WAIT;
            end
            default: next_state = FPS_ST_WAIT;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            state <= FPS_ST_WAIT;
        else
            state <= next_state;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end

    // overpower timer, cleared on any gap
    always_ff @(posedge clk_in) begin
        if (rst_in || !fl.overpower || !switching)
            opp_cnt <= '0;
        // saturates rather than wrapping
        else if (tick && opp_cnt != 16'hffff)
            opp_cnt <= opp_cnt + 16'h1;
    end

    wire start_clear = (next_state == FPS_ST_RESTART) || (next_state == FPS_ST_WAIT)
        || (next_state == FPS_ST_LATCHED);
    wire next_started = !start_clear && (started || (switching && fl.in_regulation));
    always_ff @(posedge clk_in) begin
        if (rst_in)
            started <= 1'b0;
        else
            started <= next_started;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !fl.fault_low) begin
            prot_cnt <= '0;
            prot_fault <= 1'b0;
        end else if (tick) begin
            if (prot_cnt >= 8'(PROT_FILT_T - 1))
                prot_fault <= 1'b1;
            else
                prot_cnt <= prot_cnt + 8'h1;
        end
    end

    // aux sample held through secondary stroke
    always_ff @(posedge clk_in) begin
        if (rst_in || primary_end)
            secondary_ovp_seen <= 1'b0;
        else if (fl.secondary_stroke && fl.aux_ovp)
            secondary_ovp_seen <= 1'b1;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !switching) begin
            ovp_cnt <= '0;
            ovp_seen <= 1'b0;
        end else begin
            // keep a detection seen between two ticks
            if (ovp_clock)
                ovp_seen <= 1'b0;
            else if (fl.fault_low && (secondary_ovp_seen || fl.low_supply_ovp))
                ovp_seen <= 1'b1;
            if (ovp_clock) begin
                if (ovp_seen || ovp_now)
                    ovp_cnt <= (ovp_cnt == 3'(OVP_PULSES - 1)) ? ovp_cnt : ovp_cnt + 3'h1;
                else
                    ovp_cnt <= '0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !gate_q)
            on_cnt <= '0;
        else
            on_cnt <= on_cnt + 16'h1;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || state != FPS_ST_RESTART)
            restart_cnt <= '0;
        else if (tick)
            restart_cnt <= restart_cnt + 16'h1;
    end

    wire [7:0] fb_err_hi = feedback_ua_in - FB_TARGET_UA;
    wire [7:0] fb_err_lo = FB_TARGET_UA - feedback_ua_in;
    wire fb_high = feedback_ua_in > FB_TARGET_UA;
    wire fb_fast = feedback_ua_in <= FB_TARGET_UA - FB_FAST_DROP_UA;
    wire [15:0] slow_step_hi = 16'(fb_err_hi) >> SLOW_SHIFT;
    wire [15:0] slow_step_lo = 16'(fb_err_lo) >> SLOW_SHIFT;
    wire [15:0] step_lo = fb_fast ? 16'(fb_err_lo) : slow_step_lo;
    wire [16:0] offset_up = 17'(offset) + 17'(step_lo);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            offset <= OFFSET_RESET;
        end else if (tick && switching) begin
            if (fb_high)
                offset <= (offset > slow_step_hi) ? offset - slow_step_hi : '0;
            else
                offset <= offset_up[16] ? 16'hffff : offset_up[15:0];
        end
    end

    // registered outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gate_q <= 1'b0;
            supply_out <= '0;
            power_offset_out <= OFFSET_RESET;
            fast_mode_out <= 1'b0;
            state_out <= FPS_ST_WAIT;
            latch_fault_out <= 1'b0;
            restart_fault_out <= 1'b0;
        end else begin
            gate_q <= next_gate;
            supply_out.supply_regulate <= !next_started;
            // fast discharge on entry
            // latch discharge lasts one cycle, restart's the whole state
            supply_out.supply_discharge <= (next_state == FPS_ST_RESTART)
                || (next_state == FPS_ST_LATCHED && state != FPS_ST_LATCHED);
            supply_out.fault_source_en <= next_state == FPS_ST_SOURCES
                || next_state == FPS_ST_SOFTSTART || next_state == FPS_ST_RUN;
            supply_out.feedback_source_en <= next_state == FPS_ST_SOURCES
                || next_state == FPS_ST_SOFTSTART || next_state == FPS_ST_RUN;
            supply_out.softstart_en <= next_state == FPS_ST_SOFTSTART;
            power_offset_out <= offset;
            fast_mode_out <= fb_fast;
            state_out <= next_state;
            latch_fault_out <= next_state == FPS_ST_LATCHED;
            restart_fault_out <= next_state == FPS_ST_RESTART;
        end
    end

    assign gate_drive_out = gate_q;
endmodule

// *** bench/fps_supervisor_sva.sv ***
// assertions on the supervisor ports
`timescale 1ns/1ps
module fps_supervisor_sva
    import fps_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic rst_in,
    input wire fps_flags_t flags_in,
    input wire logic gate_drive_out,
    input wire fps_supply_t supply_out,
    input wire fps_state_t state_out,
    input wire logic latch_fault_out,
    input wire logic restart_fault_out
);
    int on_cnt;
    always_ff @(posedge clk_in) begin
        on_cnt <= (rst_in || !gate_drive_out) ? 0 : on_cnt + 1;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    property p_opp_cut;
        flags_in.overpower [*4] |-> !gate_drive_out;
    endproperty
    a_opp_cut: assert property (p_opp_cut) else $error("gate on in overpower");
    property p_hot_off;
        flags_in.junction_hot [*4] |-> !gate_drive_out;
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("gate on when hot");
    property p_latch_hold;
        state_out == FPS_ST_LATCHED |-> !gate_drive_out && supply_out.supply_regulate;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched output wrong");
    property p_restart_hold;
        state_out == FPS_ST_RESTART |-> !gate_drive_out && supply_out.supply_discharge;
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart output wrong");
    property p_latch_dis;
        $rose(latch_fault_out) |-> ##[0:1] supply_out.supply_discharge;
    endproperty
    a_latch_dis: assert property (p_latch_dis) else $error("no discharge on latch");
    property p_flags;
        latch_fault_out == (state_out == FPS_ST_LATCHED)
            && !(latch_fault_out && restart_fault_out);
    endproperty
    a_flags: assert property (p_flags) else $error("fault flags wrong");
    property p_sources;
        state_out == FPS_ST_SOURCES
            |-> supply_out.fault_source_en && supply_out.feedback_source_en;
    endproperty
    a_sources: assert property (p_sources) else $error("sources off");
    property p_ontime;
        on_cnt <= MAX_ON_CYC + 1;
    endproperty
    a_ontime: assert property (p_ontime) else $error("on time too long");
endmodule

// *** bench/fps_analog_model.sv ***
// stroke and overvoltage comparator model
`timescale 1ns/1ps
module fps_analog_model (
    // clock and gate
    input wire logic clk_in,
    input wire logic gate_in,
    // commanded overvoltage
    input wire logic ovp_level_in,
    // comparator levels
    output logic secondary_stroke_out,
    output logic aux_ovp_out
);
    logic [3:0] cnt = 4'h0;
    logic gate_q = 1'b0;
    logic junk = 1'b0;
    always_ff @(posedge clk_in) begin
        gate_q <= gate_in;
        junk <= ~junk;
        cnt <= (gate_q && !gate_in) ? 4'h8 : cnt - {3'h0, cnt != 4'h0};
    end
    assign secondary_stroke_out = (cnt != 4'h0);
    assign aux_ovp_out = secondary_stroke_out ? ovp_level_in : junk;
endmodule

// *** bench/tb_top.sv ***
// bench for the protection supervisor
`timescale 1ns/1ps
module tb_top;
    import fps_pkg::*;
    localparam int TC = 20;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    fps_flags_t flags = '0;
    fps_flags_t flags_in;
    logic gate_request_in = 1'b0;
    logic [7:0] feedback_ua_in = 8'h50;
    logic ovp = 1'b0;
    logic sec;
    logic aux;
    logic gate_drive_out;
    fps_supply_t supply_out;
    fps_state_t state_out;
    logic [15:0] power_offset_out;
    logic fast_mode_out;
    logic latch_fault_out;
    logic restart_fault_out;
    int errors = 0;
    int cmp_count = 0;
    always_comb begin
        flags_in = flags;
        flags_in.aux_ovp = aux;
        flags_in.secondary_stroke = sec;
    end
    fps_supervisor #(.OPP_NORMAL_T(10), .OPP_START_T(4), .PROT_FILT_T(3), .RESTART_T(3),
        .TICK_C(TC)) fps_supervisor_i (.clk_in(clk_in), .rst_in(rst_in), .flags_in(flags_in),
        .gate_request_in(gate_request_in), .feedback_ua_in(feedback_ua_in),
        .gate_drive_out(gate_drive_out), .supply_out(supply_out),
        .power_offset_out(power_offset_out), .fast_mode_out(fast_mode_out),
        .state_out(state_out), .latch_fault_out(latch_fault_out),
        .restart_fault_out(restart_fault_out));
    fps_analog_model fps_analog_model_i (.clk_in(clk_in), .gate_in(gate_drive_out),
        .ovp_level_in(ovp), .secondary_stroke_out(sec), .aux_ovp_out(aux));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic ck(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ws(input fps_state_t s, input int lim, output int n);
        n = 0;
        while (state_out !== s && n < lim) begin
            @(negedge clk_in);
            n++;
        end
        ck("state", s, state_out);
        if (state_out !== s) begin
            end_of_test();
        end
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_in);
            gate_request_in <= 1'b1;
            repeat (10) @(posedge clk_in);
            gate_request_in <= 1'b0;
            repeat (20) @(posedge clk_in);
        end
        @(negedge clk_in);
    endtask
    task automatic t_start(input logic reg_ok);
        int n;
        @(posedge clk_in);
        flags.mains_ok <= 1'b1;
        flags.pins_ready <= 1'b0;
        flags.in_regulation <= 1'b0;
        ws(FPS_ST_SOURCES, 10, n);
        @(posedge clk_in);
        flags.pins_ready <= 1'b1;
        ws(FPS_ST_SOFTSTART, 10, n);
        ck("soft", 2'b11, {supply_out.softstart_en, supply_out.supply_regulate});
        @(posedge clk_in);
        flags.in_regulation <= reg_ok;
        if (reg_ok) begin
            ws(FPS_ST_RUN, 10, n);
            ck("run reg", 1'b0, supply_out.supply_regulate);
        end
    endtask
    task automatic t_latch(input int sel);
        int n;
        pulse(4);
        ck("no trip", 1'b0, latch_fault_out);
        @(posedge clk_in);
        ovp <= (sel == 0);
        flags.low_supply_ovp <= (sel == 3);
        flags.junction_hot <= (sel == 1);
        flags.fault_low <= (sel == 2);
        if (sel == 0 || sel == 3) begin
            pulse(3);
            ck("three", 1'b0, latch_fault_out);
            pulse(2);
        end else begin
            repeat (2 * TC - 5) @(negedge clk_in);
            ck("filter", sel == 1, latch_fault_out);
        end
        ws(FPS_ST_LATCHED, 3 * TC, n);
        repeat (TC) @(negedge clk_in);
        ck("latched", 2'b01, {gate_drive_out, supply_out.supply_regulate});
        @(posedge clk_in);
        flags <= '0;
        ovp <= 1'b0;
        ws(FPS_ST_WAIT, 10, n);
    endtask
    task automatic t_opp(input logic reg_ok, input logic supply_undervoltage_lockout);
        int n;
        int lim;
        lim = supply_undervoltage_lockout ? 0 : (reg_ok ? 10 * TC : 4 * TC);
        @(posedge clk_in);
        gate_request_in <= 1'b1;
        repeat (4) @(negedge clk_in);
        ck("gate on", 1'b1, gate_drive_out);
        @(posedge clk_in);
        flags.overpower <= 1'b1;
        flags.supply_undervoltage_lockout <= supply_undervoltage_lockout;
        repeat (4) @(negedge clk_in);
        ck("gate cut", 1'b0, gate_drive_out);
        ws(FPS_ST_RESTART, supply_undervoltage_lockout ? 6 : lim + TC, n);
        ck("opp time", 1'b1, n >= lim - TC - 4);
        ck("restart", 6'b111000, {restart_fault_out, supply_out});
        @(posedge clk_in);
        flags.overpower <= 1'b0;
        flags.supply_undervoltage_lockout <= 1'b0;
        flags.pins_ready <= 1'b0;
        gate_request_in <= 1'b0;
        flags.mains_ok <= !reg_ok;
        if (reg_ok) begin
            ws(FPS_ST_WAIT, 6, n);
        end else begin
            ws(FPS_ST_SOURCES, 5 * TC, n);
            ck("delay", 1'b1, n >= 2 * TC);
        end
    endtask
    task automatic t_loop();
        logic [15:0] o;
        @(posedge clk_in);
        feedback_ua_in <= 8'h90;
        repeat (3 * TC) @(negedge clk_in);
        o = power_offset_out;
        ck("fast off", 1'b0, fast_mode_out);
        repeat (2 * TC) @(negedge clk_in);
        ck("offset down", 1'b1, power_offset_out < o);
        @(posedge clk_in);
        feedback_ua_in <= 8'h28;
        repeat (3 * TC) @(negedge clk_in);
        o = power_offset_out;
        ck("fast on", 1'b1, fast_mode_out);
        repeat (2 * TC) @(negedge clk_in);
        ck("offset up", 1'b1, power_offset_out > o);
    endtask
    task automatic t_maxon();
        int n;
        @(posedge clk_in);
        gate_request_in <= 1'b1;
        feedback_ua_in <= 8'h28;
        ws(FPS_ST_RESTART, MAX_ON_CYC + 10, n);
        ck("max on", 1'b1, n >= MAX_ON_CYC - 5);
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            t_start(1'b1);
            t_latch(s);
        end
        t_start(1'b1);
        t_opp(1'b1, 1'b0);
        t_start(1'b1);
        t_opp(1'b1, 1'b1);
        t_start(1'b0);
        t_opp(1'b0, 1'b0);
        t_start(1'b1);
        t_loop();
        t_maxon();
        end_of_test();
    end
endmodule
bind fps_supervisor fps_supervisor_sva fps_supervisor_sva_i (.clk_in(clk_in), .rst_in(rst_in),
    .flags_in(flags_in), .gate_drive_out(gate_drive_out), .supply_out(supply_out),
    .state_out(state_out), .latch_fault_out(latch_fault_out),
    .restart_fault_out(restart_fault_out));
